// ---- logic/upc_defines.svh ----
`ifndef UPC_DEFINES_SVH
`define UPC_DEFINES_SVH

// configuration dword offsets
`define UPC_OFS_PORT3 8'hA8
`define UPC_OFS_PORT4 8'hAC
`define UPC_OFS_CAP 8'hE0

// width of the stored part of each register
`define UPC_TUNE_W 24
`define UPC_CAP_W 24

// tuning register reset image: disc 10b, squelch 10b, cal 100b, fs 01b, ls 01b
`define UPC_TUNE_RST 24'h14_9400

// capability dword reset image: id 10h, next 00h, version 1h, type 1h
`define UPC_CAP_RST 24'h11_0010

// capability dword field positions
`define UPC_CAPID_LSB 0
`define UPC_NEXT_LSB 8
`define UPC_VER_LSB 16
`define UPC_TYPE_LSB 20
`define UPC_SLOT_BIT 24
`define UPC_MSGNUM_LSB 25

`endif

// ---- logic/upc_pkg.sv ----
package upc_pkg;

  // which register an offset lands on
  typedef enum logic [1:0] {
    UPC_SEL_NONE,
    UPC_SEL_PORT3,
    UPC_SEL_PORT4,
    UPC_SEL_CAP
  } upc_sel_t;

  // whole state of the register bank
  typedef struct packed {
    logic [23:0] port3;
    logic [23:0] port4;
    logic [23:0] cap;
    logic ack;
    logic [31:0] rdata;
    logic pristine;
  } upc_state_t;

endpackage : upc_pkg

// ---- logic/upc_regs.sv ----
`timescale 1ns/1ps
`include "upc_defines.svh"

// Behaviour
// [RULE1] tuning strength, amplitude, slope reset to zero
// [RULE2] disconnect and squelch references reset to 10b
// [RULE3] calibration reference resets to 100b
// [RULE4] fs and ls edge rates reset 01b
// [RULE5] pll current and pre-emphasis reset 00b
// [RULE6] host sees read-only; sideband or eeprom loads
// [RULE7] port3 at A8h, port4 at ACh, same layout
// [RULE8] E0h byte zero reads capability id 10h
// [RULE9] next pointer reads 00h, list ends
// [RULE10] capability version reads 0001b
// [RULE11] device/port type resets to 1h
// [RULE12] slot implemented bit tied zero
// [RULE13] interrupt message number tied zero
// [RULE14] host writes complete but change nothing
// [RULE15] unused upper bits always read zero
module upc_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // host configuration access
  input wire logic i_cfg_req,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  // sideband default loading (smbus slave or eeprom loader)
  input wire logic i_sb_wr,
  input wire logic [7:0] i_sb_addr,
  input wire logic [31:0] i_sb_wdata,
  // tuning values towards the phys of ports 3 and 4
  output logic [23:0] o_port3_tuning,
  output logic [23:0] o_port4_tuning
);

  upc_pkg::upc_state_t st_q;
  upc_pkg::upc_state_t st_d;

  // one decoder shared by the host and sideband paths
  function automatic upc_pkg::upc_sel_t upc_sel(input logic [7:0] addr);
    upc_pkg::upc_sel_t s;
    s = upc_pkg::UPC_SEL_NONE;
    case (addr)
      `UPC_OFS_PORT3: s = upc_pkg::UPC_SEL_PORT3; // [RULE7]
      `UPC_OFS_PORT4: s = upc_pkg::UPC_SEL_PORT4; // [RULE7]
      `UPC_OFS_CAP: s = upc_pkg::UPC_SEL_CAP;
      default: s = upc_pkg::UPC_SEL_NONE;
    endcase
    return s;
  endfunction : upc_sel

  // read image; unused upper bits and unmapped offsets give zero
  function automatic logic [31:0] upc_read(input upc_pkg::upc_state_t st,
                                           input logic [7:0] addr);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (upc_sel(addr))
      upc_pkg::UPC_SEL_PORT3: r = {8'h00, st.port3}; // [RULE15]
      upc_pkg::UPC_SEL_PORT4: r = {8'h00, st.port4}; // [RULE7]
      // slot bit, message number and reserved bits stay zero
      upc_pkg::UPC_SEL_CAP: r = {8'h00, st.cap}; // [RULE12] [RULE13]
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : upc_read

  // next state: sideband loads defaults, host only reads
  always_comb begin
    st_d = st_q;
    st_d.ack = 1'b0;
    // only the sideband path may replace stored values
    if (i_sb_wr) begin // [RULE6]
      st_d.pristine = 1'b0;
      case (upc_sel(i_sb_addr))
        upc_pkg::UPC_SEL_PORT3: st_d.port3 = i_sb_wdata[23:0];
        upc_pkg::UPC_SEL_PORT4: st_d.port4 = i_sb_wdata[23:0];
        upc_pkg::UPC_SEL_CAP: st_d.cap = i_sb_wdata[23:0];
        default: st_d.pristine = st_q.pristine;
      endcase
    end
    // host access: always acknowledged next cycle
    if (i_cfg_req) begin
      st_d.ack = 1'b1;
      // writes are swallowed so the host cannot disturb tuning
      if (!i_cfg_wr) begin // [RULE14]
        st_d.rdata = upc_read(st_q, i_cfg_addr);
      end
    end
  end

  // state register with the power-on images
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q.port3 <= `UPC_TUNE_RST; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
      st_q.port4 <= `UPC_TUNE_RST;
      st_q.cap <= `UPC_CAP_RST; // [RULE8] [RULE9] [RULE10] [RULE11]
      st_q.ack <= 1'b0;
      st_q.rdata <= 32'h0000_0000;
      st_q.pristine <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign o_cfg_ack = st_q.ack;
  assign o_cfg_rdata = st_q.rdata;
  assign o_port3_tuning = st_q.port3;
  assign o_port4_tuning = st_q.port4;

  // i_cfg_wdata is deliberately unused: config writes have no effect

  default clocking upc_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // host read requests of each register, and a host write without a sideband write
  sequence s_rd_p3;
    i_cfg_req && !i_cfg_wr && i_cfg_addr == `UPC_OFS_PORT3;
  endsequence
  sequence s_rd_p4;
    i_cfg_req && !i_cfg_wr && i_cfg_addr == `UPC_OFS_PORT4;
  endsequence
  sequence s_rd_cap;
    i_cfg_req && !i_cfg_wr && i_cfg_addr == `UPC_OFS_CAP;
  endsequence
  sequence s_host_wr;
    i_cfg_req && i_cfg_wr && !i_sb_wr;
  endsequence

  AST_TUNE_ZERO_FIELDS: assert property ( // [RULE1]
    st_q.pristine |-> (o_port3_tuning[8:0] == 9'h000 && o_port4_tuning[8:0] == 9'h000))
    else $error("tuning strength, amplitude or slope not zero after reset");

  AST_TUNE_REF_10: assert property ( // [RULE2]
    st_q.pristine |-> (o_port3_tuning[12:9] == 4'hA && o_port4_tuning[12:9] == 4'hA))
    else $error("disconnect or squelch reference not 10b after reset");

  AST_TUNE_CAL_100: assert property ( // [RULE3]
    st_q.pristine |-> (o_port3_tuning[15:13] == 3'h4 && o_port4_tuning[15:13] == 3'h4))
    else $error("calibration reference not 100b after reset");

  AST_TUNE_EDGE_01: assert property ( // [RULE4]
    st_q.pristine |-> (o_port3_tuning[21:18] == 4'h5 && o_port4_tuning[21:18] == 4'h5))
    else $error("edge rate fields not 01b after reset");

  AST_TUNE_PLL_PRE_00: assert property ( // [RULE5]
    st_q.pristine |-> (o_port3_tuning[17:16] == 2'h0 && o_port4_tuning[23:22] == 2'h0
                    && o_port4_tuning[17:16] == 2'h0 && o_port3_tuning[23:22] == 2'h0))
    else $error("pll current or pre-emphasis not 00b after reset");

  AST_ONLY_SIDEBAND_LOADS: assert property ( // [RULE6]
    !i_sb_wr |=> ($stable(st_q.port3) && $stable(st_q.port4) && $stable(st_q.cap)))
    else $error("stored value changed without a sideband write");

  AST_SB_LOAD_P3: assert property ( // [RULE6]
    i_sb_wr && i_sb_addr == `UPC_OFS_PORT3 |=> o_port3_tuning == $past(i_sb_wdata[23:0]))
    else $error("sideband load of port 3 tuning not taken");

  AST_READ_P3: assert property ( // [RULE7]
    s_rd_p3 |=> o_cfg_ack && o_cfg_rdata == {8'h00, $past(st_q.port3)})
    else $error("port 3 tuning read returned wrong data");

  AST_READ_P4: assert property ( // [RULE7]
    s_rd_p4 |=> o_cfg_ack && o_cfg_rdata == {8'h00, $past(st_q.port4)})
    else $error("port 4 tuning read returned wrong data");

  AST_CAP_ID: assert property ( // [RULE8]
    s_rd_cap ##0 st_q.pristine |=> o_cfg_rdata[7:0] == 8'h10)
    else $error("capability id not 10h");

  AST_CAP_NEXT: assert property ( // [RULE9]
    s_rd_cap ##0 st_q.pristine |=> o_cfg_rdata[15:8] == 8'h00)
    else $error("next pointer not 00h");

  AST_CAP_VERSION: assert property ( // [RULE10]
    s_rd_cap ##0 st_q.pristine |=> o_cfg_rdata[19:16] == 4'h1)
    else $error("capability version not 0001b");

  AST_CAP_TYPE: assert property ( // [RULE11]
    s_rd_cap ##0 st_q.pristine |=> o_cfg_rdata[23:20] == 4'h1)
    else $error("device/port type not 1h");

  AST_CAP_SLOT: assert property ( // [RULE12]
    s_rd_cap |=> !o_cfg_rdata[`UPC_SLOT_BIT])
    else $error("slot implemented bit set");

  AST_CAP_MSGNUM: assert property ( // [RULE13]
    s_rd_cap |=> o_cfg_rdata[29:25] == 5'h00)
    else $error("interrupt message number not zero");

  AST_HOST_WR_NOP: assert property ( // [RULE14]
    s_host_wr |=> o_cfg_ack && $stable(o_cfg_rdata) && $stable(st_q.port3)
                  && $stable(st_q.port4) && $stable(st_q.cap))
    else $error("host write altered state or was not acknowledged");

  AST_UPPER_ZERO: assert property ( // [RULE15]
    (s_rd_p3 or s_rd_p4) |=> o_cfg_rdata[31:24] == 8'h00)
    else $error("tuning upper byte not zero");

  AST_CAP_RSVD: assert property ( // [RULE15]
    s_rd_cap |=> o_cfg_rdata[31:30] == 2'h0)
    else $error("capability reserved bits not zero");

  // sideband writes to the other two registers land one cycle later
  AST_SB_LOAD_P4: assert property ( // [RULE6]
    i_sb_wr && i_sb_addr == `UPC_OFS_PORT4 |=> o_port4_tuning == $past(i_sb_wdata[23:0]))
    else $error("sideband load of port 4 tuning not taken");

  AST_SB_LOAD_CAP: assert property ( // [RULE6]
    i_sb_wr && i_sb_addr == `UPC_OFS_CAP |=> st_q.cap == $past(i_sb_wdata[23:0]))
    else $error("sideband load of capability dword not taken");

  // a stray answer would confuse the host's completion tracking
  AST_ACK_NEEDS_REQ: assert property ( // [RULE14]
    !i_cfg_req |=> !o_cfg_ack)
    else $error("acknowledge without a host request");

  // unmapped offsets must not leak stale or stored data
  AST_UNMAPPED_ZERO: assert property ( // [RULE7]
    i_cfg_req && !i_cfg_wr && upc_sel(i_cfg_addr) == upc_pkg::UPC_SEL_NONE
    |=> o_cfg_rdata == 32'h0000_0000)
    else $error("unmapped offset did not read zero");

endmodule : upc_regs

// ---- tb/upc_host_model.sv ----
`timescale 1ns/1ps
// host side of configuration space: one access per pulse, answer one cycle later
module upc_host_model (
  // clock
  input wire logic i_clk,
  // request towards the register bank
  output logic o_req,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata,
  // answer from the register bank
  input wire logic i_ack,
  input wire logic [31:0] i_rdata
);
  initial begin
    o_req = 1'b0;
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_wdata = 32'h0000_0000;
  end
  // drive on the falling edge, take the answer at the next falling edge, half a cycle after the taking edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ack);
    @(negedge i_clk);
    o_req = 1'b1;
    o_wr = wr;
    o_addr = a;
    o_wdata = wd;
    @(negedge i_clk);
    o_req = 1'b0;
    ack = i_ack;
    rd = i_rdata;
    // released lines must not keep their last value
    o_addr = ~a;
    o_wdata = ~wd;
  endtask : access
endmodule : upc_host_model

// ---- tb/usb_phy_tuning_and_pcie_cap_regs_tb.sv ----
`timescale 1ns/1ps
module usb_phy_tuning_and_pcie_cap_regs_tb;
  logic i_clk, i_arst_n, req, wr, ack, sb_wr, got_ack;
  logic [7:0] addr, sb_addr;
  logic [31:0] wdata, rdata, sb_wdata, got;
  logic [23:0] p3, p4;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // expected images built field by field, msb first
  localparam logic [31:0] TUNE = {8'h00, 2'b00, 2'b01, 2'b01, 2'b00, 3'b100, 2'b10, 2'b10,
                                  4'h0, 2'b00, 2'b00, 1'b0};
  localparam logic [31:0] CAP = {2'b00, 5'h00, 1'b0, 4'h1, 4'h1, 8'h00, 8'h10};
  localparam logic [31:0] ONES = 32'h00FF_FFFF;
  upc_regs dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cfg_req(req), .i_cfg_wr(wr),
    .i_cfg_addr(addr), .i_cfg_wdata(wdata), .o_cfg_ack(ack), .o_cfg_rdata(rdata),
    .i_sb_wr(sb_wr), .i_sb_addr(sb_addr), .i_sb_wdata(sb_wdata),
    .o_port3_tuning(p3), .o_port4_tuning(p4));
  upc_host_model host_u (.i_clk(i_clk), .o_req(req), .o_wr(wr), .o_addr(addr),
    .o_wdata(wdata), .i_ack(ack), .i_rdata(rdata));
  // clock generator
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // hang guard, far above the fewer than fifty cycles the tests need
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks made %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // every access must be answered, so ack is checked on each read
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    host_u.access(1'b0, a, 32'h0000_0000, got, got_ack);
    check({31'h0, got_ack}, 32'h0000_0001);
    check(got, exp);
  endtask : rd
  // sideband strobe for one cycle, lines scrambled afterwards
  task automatic sb(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_clk);
    sb_wr = 1'b1;
    sb_addr = a;
    sb_wdata = d;
    @(negedge i_clk);
    sb_wr = 1'b0;
    sb_addr = ~a;
    sb_wdata = ~d;
  endtask : sb
  // called at time zero or right after a falling edge, so reset spans exactly 3 cycles
  task automatic do_reset();
    i_arst_n = 1'b0;
    repeat (3) @(negedge i_clk);
    i_arst_n = 1'b1;
  endtask : do_reset
  // main sequence
  initial begin
    sb_wr = 1'b0;
    sb_addr = 8'h00;
    sb_wdata = 32'h0000_0000;
    do_reset();
    rd(8'hA8, TUNE);
    rd(8'hAC, TUNE);
    rd(8'hE0, CAP);
    check({8'h00, p3}, TUNE);
    $display("test reset defaults done");
    host_u.access(1'b1, 8'hA8, 32'hFFFF_FFFF, got, got_ack);
    check({31'h0, got_ack}, 32'h0000_0001);
    check(got, CAP);
    host_u.access(1'b1, 8'hE0, 32'hFFFF_FFFF, got, got_ack);
    check({31'h0, got_ack}, 32'h0000_0001);
    rd(8'hA8, TUNE);
    rd(8'hE0, CAP);
    $display("test host writes done");
    sb(8'hAC, 32'hFFFF_FFFF);
    sb(8'hE0, 32'hFFFF_FFFF);
    sb(8'hA4, 32'h0000_0000);
    rd(8'hAC, ONES);
    rd(8'hA8, TUNE);
    rd(8'hE0, ONES);
    rd(8'hA4, 32'h0000_0000);
    sb(8'hA8, 32'hA512_3456);
    rd(8'hA8, 32'h0012_3456);
    check({8'h00, p3}, 32'h0012_3456);
    check({8'h00, p4}, ONES);
    $display("test sideband load done");
    do_reset();
    rd(8'hAC, TUNE);
    rd(8'hE0, CAP);
    rd(8'hA8, TUNE);
    check({8'h00, p4}, TUNE);
    $display("test second reset done");
    test_done();
  end
endmodule : usb_phy_tuning_and_pcie_cap_regs_tb
